// ---- bench/tpr_rom_model.sv ----
// Serial ROM and terminal line driver at the loader's far side
`timescale 1ns/1ps
module tpr_rom_model
(
    input  wire logic         ref_clk,
    input  wire logic         rom_clock_out,
    input  wire logic         rom_output_enable_n,
    input  wire logic         term_bit,
    input  wire logic [319:0] image,
    output logic              rom_serial_in
);
    logic       prev = 1'b0;
    logic [1:0] dly  = 2'h0;
    int         idx  = 0;

    // New bit four clocks after the rise: just past the hold time
    always @(posedge ref_clk)
    begin
        prev <= rom_clock_out;
        if (rom_output_enable_n)
        begin
            idx <= 0;
            dly <= 2'h0;
        end
        else if (rom_clock_out && !prev)
            dly <= 2'h3;
        else if (dly != 2'h0)
        begin
            dly <= dly - 2'h1;
            if (dly == 2'h1)
                idx <= idx + 1;
        end
    end

    // Junk past the image end
    assign rom_serial_in = rom_output_enable_n ? term_bit :
        (idx < 320 ? image[idx] : ~image[319]);
endmodule

// ---- bench/tpr_test_port_checker.sv ----
// Assertion checker for the test port and ROM loader
`timescale 1ns/1ps
module tpr_test_port_checker
    import tpr_pkg::*;
(
    input wire logic               ref_clk,
    input wire logic               rst_n,
    input wire logic [ADDR_W-1:0]  reg_addr,
    input wire logic [31:0]        reg_wdata,
    input wire logic               reg_wr,
    input wire logic               rom_serial_in,
    input wire logic               rom_clock_out,
    input wire logic               rom_output_enable_n,
    input wire logic               fill_valid,
    input wire logic [FILL_AW-1:0] fill_addr,
    input wire logic               fill_is_config,
    input wire logic               load_done,
    input wire logic               serial_receive_bit,
    input wire logic               trap_request,
    input wire logic               trst_n,
    input wire logic               tdo_oe,
    input wire logic               bsr_drive_en,
    input wire logic               bsr_highz
);
    logic [8:0]         run;
    logic               pv;
    logic               seen;
    logic               priv_sh;
    logic [3:0]         up;
    logic [FILL_AW-1:0] exp_a;
    logic               ctrl_w;

    assign ctrl_w = reg_wr && reg_addr == REG_CTRL;

    // ROM clock level run length, saturating
    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            run     <= 9'h000;
            pv      <= 1'b0;
            seen    <= 1'b0;
            priv_sh <= 1'b0;
            up      <= 4'h0;
            exp_a   <= '0;
        end
        else
        begin
            pv    <= rom_clock_out;
            seen  <= seen || rom_clock_out != pv;
            run   <= (rom_clock_out != pv) ? 9'h001 : run + 9'(run != 9'h1FF);
            up    <= up + 4'(up != 4'hF);
            if (ctrl_w)
                priv_sh <= reg_wdata[CTRL_PRIV];
            if (fill_valid)
                exp_a <= exp_a + 1'b1;
        end
    end

    default clocking @(posedge ref_clk); endclocking
    default disable iff (!rst_n);

    sequence s_pin_write;
        load_done ##0 ctrl_w;
    endsequence
    sequence s_rx_quiet;
        (up[3] && $stable(rom_serial_in))[*6];
    endsequence

    chk_load_enable: assert property (rom_output_enable_n == load_done)
        else $error("ROM enable vs load state");
    chk_done_hold: assert property (load_done |=> load_done)
        else $error("terminal mode left");
    chk_rom_period: assert property (seen && !load_done && rom_clock_out != pv
        |-> run == 9'h080 || run == 9'h008)
        else $error("bad ROM half period");
    chk_fill_pulse: assert property (fill_valid
        |-> !rom_output_enable_n ##1 !fill_valid)
        else $error("bad fill pulse");
    chk_fill_index: assert property (fill_valid |-> fill_addr == exp_a
        && fill_is_config == (fill_addr >= CFG_FIRST))
        else $error("bad fill index");
    chk_fill_count: assert property ($rose(load_done) |-> exp_a == LOAD_WORDS)
        else $error("bad word count");
    chk_pin_write: assert property (s_pin_write
        |=> rom_clock_out == $past(reg_wdata[CTRL_XMIT]))
        else $error("pin missed write");
    chk_pin_hold: assert property (load_done && !ctrl_w
        |=> $stable(rom_clock_out))
        else $error("pin moved unwritten");
    chk_rx_follow: assert property (s_rx_quiet
        |-> serial_receive_bit == rom_serial_in)
        else $error("receive bit lags pin");
    chk_trap_raise: assert property (load_done && !priv_sh
        && $changed(serial_receive_bit) |-> ##[0:2] trap_request)
        else $error("no receive trap");
    chk_trap_block: assert property (priv_sh |-> !trap_request)
        else $error("trap while privileged");
    chk_scan_reset: assert property (!trst_n
        |-> !bsr_highz && !bsr_drive_en && !tdo_oe)
        else $error("scan active in test reset");
endmodule

bind tpr_test_port tpr_test_port_checker u_chk (
    .ref_clk(ref_clk), .rst_n(rst_n), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .rom_serial_in(rom_serial_in),
    .rom_clock_out(rom_clock_out), .rom_output_enable_n(rom_output_enable_n),
    .fill_valid(fill_valid), .fill_addr(fill_addr),
    .fill_is_config(fill_is_config), .load_done(load_done),
    .serial_receive_bit(serial_receive_bit), .trap_request(trap_request),
    .trst_n(trst_n), .tdo_oe(tdo_oe), .bsr_drive_en(bsr_drive_en),
    .bsr_highz(bsr_highz)
);

// ---- bench/tpr_test_port_test.sv ----
// Self-checking bench for the test port and ROM loader
`timescale 1ns/1ps
module tpr_test_port_test
    import tpr_pkg::*;
;
    logic               ref_clk, rst_n, reg_wr, reg_rd, tck, tms, tdi, b;
    logic               trst_n, term_bit, rom_serial_in, rom_clock_out;
    logic               rom_output_enable_n, fill_valid, fill_is_config;
    logic               load_done, serial_receive_bit, trap_request, rd_d;
    logic               tdo, tdo_oe, bsr_drive_en, bsr_highz;
    logic [ADDR_W-1:0]  reg_addr;
    logic [31:0]        reg_wdata, reg_rdata, seed;
    logic [FILL_AW-1:0] fill_addr;
    logic [WORD_W-1:0]  fill_data;
    logic [BSR_LEN-1:0] bsr_pins_in, bsr_pins_out, g, v;
    logic [IR_W-1:0]    op, ops[5];
    logic [319:0]       image;
    logic [36:0]        rq[$], fq[$];
    int                 n_mismatch, compares, n;

    tpr_test_port uut (
        .ref_clk(ref_clk), .rst_n(rst_n), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_rdata(reg_rdata), .rom_serial_in(rom_serial_in),
        .rom_clock_out(rom_clock_out),
        .rom_output_enable_n(rom_output_enable_n), .fill_valid(fill_valid),
        .fill_addr(fill_addr), .fill_data(fill_data),
        .fill_is_config(fill_is_config), .load_done(load_done),
        .serial_receive_bit(serial_receive_bit), .trap_request(trap_request),
        .tck(tck), .tms(tms), .tdi(tdi), .trst_n(trst_n), .tdo(tdo),
        .tdo_oe(tdo_oe), .bsr_pins_in(bsr_pins_in),
        .bsr_pins_out(bsr_pins_out), .bsr_drive_en(bsr_drive_en),
        .bsr_highz(bsr_highz)
    );

    tpr_rom_model u_rom (
        .ref_clk(ref_clk), .rom_clock_out(rom_clock_out),
        .rom_output_enable_n(rom_output_enable_n), .term_bit(term_bit),
        .image(image), .rom_serial_in(rom_serial_in)
    );

    initial
    begin
        ref_clk = 1'b0;
        forever #2 ref_clk = ~ref_clk;
    end

    function automatic logic [31:0] xs();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction

    task give_verdict();
        $display("Comparisons %0d, mismatches %0d", compares, n_mismatch);
        if (n_mismatch == 0 && compares > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask

    task chk_word(input logic [36:0] gw, input logic [36:0] ew);
        compares++;
        if (gw !== ew)
        begin
            n_mismatch++;
            $display("CHECK FAILED at %0t: got %h expected %h", $time, gw, ew);
        end
    endtask

    task chk_bits(input logic [7:0] gb, input logic [7:0] eb);
        chk_word(37'(gb), 37'(eb));
    endtask

    task stuck(input logic c);
        if (c)
        begin
            n_mismatch++;
            give_verdict();
        end
    endtask

    // A stray result meets an impossible value
    always @(posedge ref_clk)
    begin
        rd_d <= reg_rd;
        if (rd_d)
            chk_word({5'h00, reg_rdata}, rq.size() ? rq.pop_front() : '1);
        if (fill_valid)
            chk_word({fill_is_config, fill_addr, fill_data},
                     fq.size() ? fq.pop_front() : '1);
    end

    task wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge ref_clk);
        reg_wr    <= 1'b1;
        reg_addr  <= a;
        reg_wdata <= d;
        @(posedge ref_clk);
        reg_wr <= 1'b0;
    endtask

    task rd(input logic [7:0] a, input logic [31:0] e);
        @(posedge ref_clk);
        reg_rd   <= 1'b1;
        reg_addr <= a;
        rq.push_back({5'h00, e});
        @(posedge ref_clk);
        reg_rd <= 1'b0;
    endtask

    // Cycles to the next ROM clock rise
    task rise(output int c);
        c = 0;
        while (rom_clock_out === 1'b1 && c < 600)
        begin
            @(posedge ref_clk);
            c++;
        end
        while (rom_clock_out !== 1'b1 && c < 600)
        begin
            @(posedge ref_clk);
            c++;
        end
        stuck(c >= 600);
    endtask

    // One 48 ns test clock; data out is taken at the rise
    task tclk(input logic m, input logic d, output logic o);
        tms = m;
        tdi = d;
        #24 tck = 1'b1;
        o = tdo;
        #24 tck = 1'b0;
    endtask

    task scan(input logic ir, input int cnt, input logic [7:0] din,
              output logic [7:0] q);
        logic o;
        tclk(1'b1, 1'b0, o);
        if (ir)
            tclk(1'b1, 1'b0, o);
        tclk(1'b0, 1'b0, o);
        tclk(1'b0, 1'b0, o);
        q = '0;
        for (int j = 0; j < cnt; j++)
        begin
            tclk(j == cnt - 1, din[j], o);
            q[j] = o;
        end
        tclk(1'b1, 1'b0, o);
        tclk(1'b0, 1'b0, o);
    endtask

    initial
    begin
        seed = 32'h00011161;
        n_mismatch = 0;
        compares = 0;
        {rst_n, trst_n, reg_wr, reg_rd, tck, tdi, term_bit, rd_d} = 8'h00;
        tms = 1'b1;
        reg_addr = '0;
        reg_wdata = '0;
        for (int i = 0; i < 10; i++)
        begin
            image[i * 32 +: 32] = xs();
            fq.push_back({i >= 8, 4'(i), image[i * 32 +: 32]});
        end
        bsr_pins_in = 8'(xs());
        ops = '{IR_SAMPLE, IR_HIGHZ, IR_CLAMP, IR_EXTEST, IR_BYPASS};
        repeat (12) @(posedge ref_clk);
        rst_n <= 1'b1;
        trst_n <= 1'b1;
        rd(REG_CTRL, 32'h0);
        rd(8'h0C, 32'h0);
        rd(REG_TAP, 32'h1F);
        chk_bits(8'(rom_output_enable_n), 8'h00);
        rise(n);
        rise(n);
        chk_word(37'(n), 37'h100);
        wr(REG_CTRL, 32'h6);
        repeat (3) rise(n);
        chk_word(37'(n), 37'h010);
        for (n = 0; n < 20000 && load_done !== 1'b1; n++)
            @(posedge ref_clk);
        stuck(n >= 20000);
        repeat (8) @(posedge ref_clk);
        chk_bits(8'(fq.size()), 8'h00);
        chk_bits({rom_output_enable_n, rom_clock_out}, 8'h02);
        rd(REG_STATUS, 32'h2);
        for (int i = 1; i >= 0; i--)
        begin
            wr(REG_CTRL, 32'h4 | i);
            #1 chk_bits(8'(rom_clock_out), 8'(i));
        end
        @(posedge ref_clk);
        term_bit <= 1'b1;
        repeat (10) @(posedge ref_clk);
        chk_bits(8'(trap_request), 8'h00);
        rd(REG_STATUS, 32'h3);
        wr(REG_CTRL, 32'h0);
        term_bit <= 1'b0;
        for (n = 0; n < 10 && trap_request !== 1'b1; n++)
            @(posedge ref_clk);
        chk_bits(8'(trap_request), 8'h01);
        rd(REG_STATUS, 32'h6);
        wr(REG_STATUS, 32'h4);
        rd(REG_STATUS, 32'h2);
        @(posedge ref_clk);
        #1 trst_n = 1'b0;
        #48 trst_n = 1'b1;
        tclk(1'b0, 1'b0, b);
        for (int i = 0; i < 5; i++)
        begin
            op = ops[i];
            scan(1'b1, IR_W, 8'(op), g);
            chk_bits(g, 8'(IR_CAPTURE));
            rd(REG_TAP, {24'h0, op == IR_HIGHZ, op == IR_CLAMP || op == IR_EXTEST,
                1'b0, op});
            v = 8'(xs());
            scan(1'b0, BSR_LEN, v, g);
            chk_bits(g, (op == IR_SAMPLE || op == IR_EXTEST) ?
                bsr_pins_in : {v[6:0], 1'b0});
            if (op == IR_EXTEST)
                chk_bits(bsr_pins_out, v);
        end
        repeat (5) tclk(1'b1, 1'b0, b);
        rd(REG_TAP, 32'h1F);
        repeat (2) @(posedge ref_clk);
        give_verdict();
    end
endmodule

// ---- hdl/tpr_pkg.sv ----
// Shared constants and types for the test port and ROM loader
package tpr_pkg;

    // Serial ROM clock, in CPU clock cycles per full period
    localparam int ROM_PERIOD_NORMAL = 256;
    localparam int ROM_PERIOD_FAST   = 16;
    localparam logic [7:0] ROM_HALF_NORMAL = 8'(ROM_PERIOD_NORMAL / 2 - 1);
    localparam logic [7:0] ROM_HALF_FAST   = 8'(ROM_PERIOD_FAST / 2 - 1);

    // Load image: cache words first, then configuration words
    localparam int WORD_W      = 32;
    localparam int CACHE_WORDS = 8;
    localparam int CFG_WORDS   = 2;
    localparam int FILL_AW     = 4;
    localparam int BIT_CW      = 5;
    localparam logic [FILL_AW-1:0] LOAD_WORDS =
        FILL_AW'(CACHE_WORDS + CFG_WORDS);
    localparam logic [FILL_AW-1:0] CFG_FIRST = FILL_AW'(CACHE_WORDS);
    localparam logic [BIT_CW-1:0]  WORD_LAST = BIT_CW'(WORD_W - 1);

    // Register port
    localparam int ADDR_W = 8;
    localparam logic [ADDR_W-1:0] REG_CTRL   = 8'h00;
    localparam logic [ADDR_W-1:0] REG_STATUS = 8'h04;
    localparam logic [ADDR_W-1:0] REG_TAP    = 8'h08;
    localparam int CTRL_XMIT   = 0;
    localparam int CTRL_FAST   = 1;
    localparam int CTRL_PRIV   = 2;
    localparam int STATUS_RX   = 0;
    localparam int STATUS_DONE = 1;
    localparam int STATUS_TRAP = 2;
    localparam logic CTRL_XMIT_RESET = 1'h0;
    localparam logic CTRL_FAST_RESET = 1'h0;
    localparam logic CTRL_PRIV_RESET = 1'h0;

    // Boundary-scan instruction register
    localparam int IR_W = 5;
    localparam logic [IR_W-1:0] IR_SAMPLE  = 5'h18;
    localparam logic [IR_W-1:0] IR_HIGHZ   = 5'h19;
    localparam logic [IR_W-1:0] IR_CLAMP   = 5'h1A;
    localparam logic [IR_W-1:0] IR_EXTEST  = 5'h1B;
    localparam logic [IR_W-1:0] IR_BYPASS  = 5'h1F;
    localparam logic [IR_W-1:0] IR_CAPTURE = 5'h01;
    localparam int BSR_LEN = 8;

    typedef enum logic [3:0] {
        TAP_RESET, TAP_IDLE,
        TAP_SEL_DR, TAP_CAP_DR, TAP_SH_DR, TAP_EX1_DR,
        TAP_PAU_DR, TAP_EX2_DR, TAP_UPD_DR,
        TAP_SEL_IR, TAP_CAP_IR, TAP_SH_IR, TAP_EX1_IR,
        TAP_PAU_IR, TAP_EX2_IR, TAP_UPD_IR
    } tpr_tap_state_t;

    typedef enum logic {
        LD_FILL,
        LD_TERMINAL
    } tpr_load_state_t;

endpackage

// ---- hdl/tpr_tap.sv ----
// Boundary-scan test access port controller, paced by sampled test clock
`timescale 1ns/1ps
module tpr_tap
    import tpr_pkg::*;
(
    input  wire logic               ref_clk,
    input  wire logic               tap_rst_n,
    input  wire logic               tck_rise,
    input  wire logic               tck_fall,
    input  wire logic               tms,
    input  wire logic               tdi,
    input  wire logic [BSR_LEN-1:0] bsr_pins_in,
    output logic                    tdo,
    output logic                    tdo_oe,
    output logic [IR_W-1:0]         ir,
    output logic [BSR_LEN-1:0]      bsr_pins_out,
    output logic                    bsr_drive_en,
    output logic                    bsr_highz
);

    typedef struct packed {
        tpr_tap_state_t     st;
        logic [IR_W-1:0]    ir;
        logic [IR_W-1:0]    ir_sh;
        logic               byp;
        logic [BSR_LEN-1:0] bsr_sh;
        logic [BSR_LEN-1:0] bsr_upd;
        logic               tdo;
        logic               tdo_oe;
    } tpr_tap_regs_t;

    tpr_tap_regs_t r;
    tpr_tap_regs_t next_r;
    logic          sel_bsr;

    // Private codes fall back to the harmless bypass path
    assign sel_bsr = (r.ir == IR_SAMPLE) || (r.ir == IR_EXTEST);

    always_comb
    begin
        next_r = r;
        if (tck_rise)
        begin
            unique case (r.st)
                TAP_CAP_IR: next_r.ir_sh = IR_CAPTURE;
                TAP_SH_IR:  next_r.ir_sh = {tdi, r.ir_sh[IR_W-1:1]};
                TAP_CAP_DR:
                begin
                    next_r.byp    = 1'b0;
                    next_r.bsr_sh = bsr_pins_in;
                end
                TAP_SH_DR:
                begin
                    if (sel_bsr)
                        next_r.bsr_sh = {tdi, r.bsr_sh[BSR_LEN-1:1]};
                    else
                        next_r.byp = tdi;
                end
                default: ;
            endcase
            unique case (r.st)
                TAP_RESET:  next_r.st = tms ? TAP_RESET  : TAP_IDLE;
                TAP_IDLE:   next_r.st = tms ? TAP_SEL_DR : TAP_IDLE;
                TAP_SEL_DR: next_r.st = tms ? TAP_SEL_IR : TAP_CAP_DR;
                TAP_CAP_DR: next_r.st = tms ? TAP_EX1_DR : TAP_SH_DR;
                TAP_SH_DR:  next_r.st = tms ? TAP_EX1_DR : TAP_SH_DR;
                TAP_EX1_DR: next_r.st = tms ? TAP_UPD_DR : TAP_PAU_DR;
                TAP_PAU_DR: next_r.st = tms ? TAP_EX2_DR : TAP_PAU_DR;
                TAP_EX2_DR: next_r.st = tms ? TAP_UPD_DR : TAP_SH_DR;
                TAP_UPD_DR: next_r.st = tms ? TAP_SEL_DR : TAP_IDLE;
                TAP_SEL_IR: next_r.st = tms ? TAP_RESET  : TAP_CAP_IR;
                TAP_CAP_IR: next_r.st = tms ? TAP_EX1_IR : TAP_SH_IR;
                TAP_SH_IR:  next_r.st = tms ? TAP_EX1_IR : TAP_SH_IR;
                TAP_EX1_IR: next_r.st = tms ? TAP_UPD_IR : TAP_PAU_IR;
                TAP_PAU_IR: next_r.st = tms ? TAP_EX2_IR : TAP_PAU_IR;
                TAP_EX2_IR: next_r.st = tms ? TAP_UPD_IR : TAP_SH_IR;
                TAP_UPD_IR: next_r.st = tms ? TAP_SEL_DR : TAP_IDLE;
            endcase
        end
        if (tck_fall)
        begin
            // Outputs move on the falling test clock
            next_r.tdo_oe = (r.st == TAP_SH_DR) || (r.st == TAP_SH_IR);
            if (r.st == TAP_SH_IR)
                next_r.tdo = r.ir_sh[0];
            else if (sel_bsr)
                next_r.tdo = r.bsr_sh[0];
            else
                next_r.tdo = r.byp;
            if (r.st == TAP_RESET)
                next_r.ir = IR_BYPASS;
            if (r.st == TAP_UPD_IR)
                next_r.ir = r.ir_sh;
            if (r.st == TAP_UPD_DR && sel_bsr)
                next_r.bsr_upd = r.bsr_sh;
        end
    end

    always_ff @(posedge ref_clk or negedge tap_rst_n)
    begin
        if (!tap_rst_n)
        begin
            r.st      <= TAP_RESET;
            r.ir      <= IR_BYPASS;
            r.ir_sh   <= IR_CAPTURE;
            r.byp     <= 1'b0;
            r.bsr_sh  <= '0;
            r.bsr_upd <= '0;
            r.tdo     <= 1'b0;
            r.tdo_oe  <= 1'b0;
        end
        else
        begin
            r <= next_r;
        end
    end

    assign tdo          = r.tdo;
    assign tdo_oe       = r.tdo_oe;
    assign ir           = r.ir;
    assign bsr_pins_out = r.bsr_upd;
    // EXTEST and CLAMP drive the held pattern; HIGHZ floats the pins
    assign bsr_drive_en = (r.ir == IR_EXTEST) || (r.ir == IR_CLAMP);
    assign bsr_highz    = (r.ir == IR_HIGHZ);

endmodule

// ---- hdl/tpr_test_port.sv ----
// Top of the test port: serial ROM loader, terminal bits and scan port
`timescale 1ns/1ps
module tpr_test_port
    import tpr_pkg::*;
(
    input  wire logic               ref_clk,
    input  wire logic               rst_n,
    input  wire logic [ADDR_W-1:0]  reg_addr,
    input  wire logic [31:0]        reg_wdata,
    input  wire logic               reg_wr,
    input  wire logic               reg_rd,
    output logic      [31:0]        reg_rdata,
    input  wire logic               rom_serial_in,
    output logic                    rom_clock_out,
    output logic                    rom_output_enable_n,
    output logic                    fill_valid,
    output logic      [FILL_AW-1:0] fill_addr,
    output logic      [WORD_W-1:0]  fill_data,
    output logic                    fill_is_config,
    output logic                    load_done,
    output logic                    serial_receive_bit,
    output logic                    trap_request,
    input  wire logic               tck,
    input  wire logic               tms,
    input  wire logic               tdi,
    input  wire logic               trst_n,
    output logic                    tdo,
    output logic                    tdo_oe,
    input  wire logic [BSR_LEN-1:0] bsr_pins_in,
    output logic      [BSR_LEN-1:0] bsr_pins_out,
    output logic                    bsr_drive_en,
    output logic                    bsr_highz
);

    typedef struct packed {
        tpr_load_state_t    lst;
        logic [7:0]         div;
        logic               rom_clk;
        logic               oe_n;
        logic [WORD_W-1:0]  shreg;
        logic [BIT_CW-1:0]  bit_cnt;
        logic [FILL_AW-1:0] word_cnt;
        logic               fill_valid;
        logic [FILL_AW-1:0] fill_addr;
        logic [WORD_W-1:0]  fill_data;
        logic               fill_cfg;
        logic               xmit;
        logic               fast;
        logic               priv;
        logic               trap_pend;
        logic [2:0]         rx_s;
        logic               rx_filt;
        logic [2:0]         tck_s;
        logic               tck_filt;
        logic [2:0]         tms_s;
        logic               tms_filt;
        logic [2:0]         tdi_s;
        logic               tdi_filt;
        logic [31:0]        rdata;
    } tpr_top_regs_t;

    tpr_top_regs_t   r;
    tpr_top_regs_t   next_r;
    logic            tck_rise;
    logic            tck_fall;
    logic            rx_change;
    logic            tap_rst_n;
    logic [IR_W-1:0] tap_ir;

    // Stage one is left to settle; stages two and three must agree
    function automatic logic agreed(input logic [2:0] s, input logic cur);
        agreed = (s[1] == s[2]) ? s[2] : cur;
    endfunction

    // Merged into the async reset: works with no test clock running
    assign tap_rst_n = rst_n & trst_n;

    assign tck_rise  = next_r.tck_filt & ~r.tck_filt;
    assign tck_fall  = ~next_r.tck_filt & r.tck_filt;
    assign rx_change = next_r.rx_filt != r.rx_filt;

    always_comb
    begin
        next_r = r;

        // Input sampling
        next_r.rx_s     = {r.rx_s[1:0], rom_serial_in};
        next_r.rx_filt  = agreed(r.rx_s, r.rx_filt);
        next_r.tck_s    = {r.tck_s[1:0], tck};
        next_r.tck_filt = agreed(r.tck_s, r.tck_filt);
        next_r.tms_s    = {r.tms_s[1:0], tms};
        next_r.tms_filt = agreed(r.tms_s, r.tms_filt);
        next_r.tdi_s    = {r.tdi_s[1:0], tdi};
        next_r.tdi_filt = agreed(r.tdi_s, r.tdi_filt);

        next_r.fill_valid = 1'b0;
        next_r.rdata      = 32'h0000_0000;

        // Register writes
        if (reg_wr && reg_addr == REG_CTRL)
        begin
            next_r.xmit = reg_wdata[CTRL_XMIT];
            next_r.fast = reg_wdata[CTRL_FAST];
            next_r.priv = reg_wdata[CTRL_PRIV];
        end
        if (reg_wr && reg_addr == REG_STATUS && reg_wdata[STATUS_TRAP])
            next_r.trap_pend = 1'b0;

        // A transition in the same cycle as the clear still lands
        if (rx_change && r.lst == LD_TERMINAL && !r.priv)
            next_r.trap_pend = 1'b1;

        // Loader and terminal pins
        unique case (r.lst)
            LD_FILL:
            begin
                next_r.oe_n = 1'b0;
                if (r.div == 8'h00)
                begin
                    // Equal high and low halves give the 50% duty
                    next_r.div     = r.fast ? ROM_HALF_FAST
                                            : ROM_HALF_NORMAL;
                    next_r.rom_clk = ~r.rom_clk;
                    if (!r.rom_clk)
                    begin
                        // Rising edge: ROM steps on, we take the old bit
                        next_r.shreg   = {r.rx_filt,
                                          r.shreg[WORD_W-1:1]};
                        next_r.bit_cnt = r.bit_cnt + BIT_CW'(1);
                        if (r.bit_cnt == WORD_LAST)
                        begin
                            next_r.fill_valid = 1'b1;
                            next_r.fill_data  = {r.rx_filt,
                                                 r.shreg[WORD_W-1:1]};
                            next_r.fill_addr  = r.word_cnt;
                            next_r.fill_cfg   = r.word_cnt >= CFG_FIRST;
                            next_r.word_cnt   = r.word_cnt
                                                + FILL_AW'(1);
                        end
                    end
                    else if (r.word_cnt == LOAD_WORDS)
                    begin
                        // Finish on a falling edge so the last pulse is whole
                        next_r.lst     = LD_TERMINAL;
                        next_r.oe_n    = 1'b1;
                        next_r.rom_clk = next_r.xmit;
                    end
                end
                else
                begin
                    next_r.div = r.div - 8'h01;
                end
            end
            LD_TERMINAL:
            begin
                next_r.oe_n    = 1'b1;
                // Pin moves on the edge that completes the write
                next_r.rom_clk = next_r.xmit;
            end
        endcase

        // Reads answer in the next cycle only
        if (reg_rd)
        begin
            unique case (reg_addr)
                REG_CTRL:
                    next_r.rdata = {29'h0000_0000, r.priv, r.fast,
                                    r.xmit};
                REG_STATUS:
                    next_r.rdata = {29'h0000_0000, r.trap_pend,
                                    r.lst == LD_TERMINAL, r.rx_filt};
                REG_TAP:
                    next_r.rdata = {24'h00_0000, bsr_highz,
                                    bsr_drive_en, 1'b0, tap_ir};
                default:
                    next_r.rdata = 32'h0000_0000;
            endcase
        end
    end

    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            r.lst        <= LD_FILL;
            r.div        <= ROM_HALF_NORMAL;
            r.rom_clk    <= 1'b0;
            r.oe_n       <= 1'b0;
            r.shreg      <= '0;
            r.bit_cnt    <= '0;
            r.word_cnt   <= '0;
            r.fill_valid <= 1'b0;
            r.fill_addr  <= '0;
            r.fill_data  <= '0;
            r.fill_cfg   <= 1'b0;
            r.xmit       <= CTRL_XMIT_RESET;
            r.fast       <= CTRL_FAST_RESET;
            r.priv       <= CTRL_PRIV_RESET;
            r.trap_pend  <= 1'b0;
            r.rx_s       <= 3'h0;
            r.rx_filt    <= 1'b0;
            r.tck_s      <= 3'h0;
            r.tck_filt   <= 1'b0;
            r.tms_s      <= 3'h7;
            r.tms_filt   <= 1'b1;
            r.tdi_s      <= 3'h7;
            r.tdi_filt   <= 1'b1;
            r.rdata      <= 32'h0000_0000;
        end
        else
        begin
            r <= next_r;
        end
    end

    tpr_tap u_tap (
        .ref_clk      (ref_clk),
        .tap_rst_n    (tap_rst_n),
        .tck_rise     (tck_rise),
        .tck_fall     (tck_fall),
        .tms          (r.tms_filt),
        .tdi          (r.tdi_filt),
        .bsr_pins_in  (bsr_pins_in),
        .tdo          (tdo),
        .tdo_oe       (tdo_oe),
        .ir           (tap_ir),
        .bsr_pins_out (bsr_pins_out),
        .bsr_drive_en (bsr_drive_en),
        .bsr_highz    (bsr_highz)
    );

    assign reg_rdata           = r.rdata;
    assign rom_clock_out       = r.rom_clk;
    assign rom_output_enable_n = r.oe_n;
    assign fill_valid          = r.fill_valid;
    assign fill_addr           = r.fill_addr;
    assign fill_data           = r.fill_data;
    assign fill_is_config      = r.fill_cfg;
    assign load_done           = r.lst == LD_TERMINAL;
    assign serial_receive_bit  = r.rx_filt;
    // Masked while privileged; only a trap already pending shows on return to native mode
    assign trap_request        = r.trap_pend & ~r.priv;

endmodule
